// ---- hw/vpg_top.sv ----
// video test-pattern generator with self-test compare, avalon register slave
// assumes received video arrives from logic on the same clock
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
module vpg_top
  import vpg_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // avalon-mm register slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // received video, one strobe per pixel
  input  wire logic        vid_pix_stb,
  input  wire logic        vid_de,
  input  wire logic        vid_hs,
  input  wire logic        vid_vs,
  input  wire logic [7:0]  vid_r,
  input  wire logic [7:0]  vid_g,
  input  wire logic [7:0]  vid_b,
  // generated video
  output logic             gen_de,
  output logic             gen_hs,
  output logic             gen_vs,
  output logic      [7:0]  gen_r,
  output logic      [7:0]  gen_g,
  output logic      [7:0]  gen_b,
  // interrupt
  output logic             irq
);
  logic [1:0] wcnt_q;
  logic       req, acc, wr_en;
  logic [7:0] widx, wdat;
  logic [3:0] sel_q;
  logic       on_q;
  logic [4:0] cfg_q;
  logic [7:0] idx_q, stctl_q, err_q;
  logic [1:0] status_q, mask_q, st_set;
  logic [7:0] tim_q [IND_FLOPS];
  logic [7:0] mem_rdata, ind_rd;
  logic       ind_wr, mem_we, low_idx;

  // bus handshake: two wait cycles, accept on the third
  assign req             = avs_read | avs_write;
  assign acc             = req && (wcnt_q == BUS_WAIT);
  assign avs_waitrequest = req && !acc;
  assign widx            = avs_address[9:2];
  assign wdat            = avs_writedata[7:0];
  assign wr_en           = acc && avs_write && avs_byteenable[0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_q <= 2'h0;
    end else if (acc || !req) begin
      wcnt_q <= 2'h0;
    end else begin
      wcnt_q <= wcnt_q + 2'h1;
    end
  end

  // direct registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q   <= CTRL_SEL_RST;
      on_q    <= 1'b0;
      cfg_q   <= CFG_RST;
      idx_q   <= BYTE_RST;
      stctl_q <= BYTE_RST;
      mask_q  <= IRQ_RST;
    end else if (wr_en) begin
      case (widx)
        REG_CTRL: begin
          sel_q <= wdat[7:4];
          on_q  <= wdat[CTRL_ON];
        end
        REG_CFG:   cfg_q   <= wdat[4:0];
        REG_INDEX: idx_q   <= wdat;
        REG_STCTL: stctl_q <= wdat;
        REG_MASK:  mask_q  <= wdat[1:0];
        default: ;
      endcase
    end
  end

  // indirect access through the index register
  assign low_idx = idx_q[7:4] == 4'h0;
  assign ind_wr  = wr_en && (widx == REG_VALUE);
  assign mem_we  = ind_wr && !low_idx;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < IND_FLOPS; i++) begin
        tim_q[i] <= BYTE_RST;
      end
    end else if (ind_wr && low_idx) begin
      tim_q[idx_q[3:0]] <= wdat;
    end
  end

  vpg_mem u_mem (
    .clock (clock),
    .rst_n (rst_n),
    .we    (mem_we),
    .addr  (idx_q),
    .wdata (wdat),
    .rdata (mem_rdata)
  );

  // indexed read value, error count shown at its own index
  always_comb begin
    if (!low_idx) begin
      ind_rd = mem_rdata;
    end else if (idx_q[3:0] == 4'(IND_ERR)) begin
      ind_rd = err_q;
    end else begin
      ind_rd = tim_q[idx_q[3:0]];
    end
  end

  // read data, loaded one cycle before the accept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && wcnt_q == 2'h1) begin
      case (widx)
        REG_CTRL:   avs_readdata <= {24'h00_0000, sel_q, 3'h0, on_q};
        REG_CFG:    avs_readdata <= {27'h000_0000, cfg_q};
        REG_INDEX:  avs_readdata <= {24'h00_0000, idx_q};
        REG_VALUE:  avs_readdata <= {24'h00_0000, ind_rd};
        REG_STCTL:  avs_readdata <= {24'h00_0000, stctl_q};
        REG_RESULT: avs_readdata <= {24'h00_0000, err_q != 8'h00,
                                     7'h00};
        REG_STATUS: avs_readdata <= {30'h0000_0000, status_q};
        REG_MASK:   avs_readdata <= {30'h0000_0000, mask_q};
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // pixel strobe: divided internal clock or incoming pixel strobe
  logic       own, div_tick, tick;
  logic [1:0] div_q;
  assign own      = cfg_q[CFG_OWN];
  assign div_tick = div_q == PIX_DIV - 2'h1;
  assign tick     = (own && !cfg_q[CFG_SRC]) ? div_tick
                                             : vid_pix_stb;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 2'h0;
    end else if (div_tick) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  // own timing from programmed totals, active sizes, widths, porches
  logic [7:0] hcnt_q, vcnt_q;
  logic [9:0] h_st, v_st, hc, vc;
  logic       h_last, v_last, own_de, own_hs, own_vs;
  assign h_last = hcnt_q == tim_q[IND_HTOT] - 8'h01;
  assign v_last = vcnt_q == tim_q[IND_VTOT] - 8'h01;
  assign h_st   = 10'(tim_q[IND_HSW]) + 10'(tim_q[IND_HBP]);
  assign v_st   = 10'(tim_q[IND_VSW]) + 10'(tim_q[IND_VBP]);
  assign hc     = 10'(hcnt_q);
  assign vc     = 10'(vcnt_q);
  assign own_de = hc >= h_st && hc < h_st + 10'(tim_q[IND_HACT])
               && vc >= v_st && vc < v_st + 10'(tim_q[IND_VACT]);
  assign own_hs = (hcnt_q < tim_q[IND_HSW]) ^ tim_q[IND_SYNC][0];
  assign own_vs = (vcnt_q < tim_q[IND_VSW]) ^ tim_q[IND_SYNC][1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= 8'h00;
      vcnt_q <= 8'h00;
    end else if (!on_q || !own) begin
      hcnt_q <= 8'h00;
      vcnt_q <= 8'h00;
    end else if (tick) begin
      hcnt_q <= h_last ? 8'h00 : hcnt_q + 8'h01;
      if (h_last) begin
        vcnt_q <= v_last ? 8'h00 : vcnt_q + 8'h01;
      end
    end
  end

  // external timing: pixel and line position from incoming de and vsync
  logic [7:0] ex_q, ey_q;
  logic       vde_q, vvs_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ex_q  <= 8'h00;
      ey_q  <= 8'h00;
      vde_q <= 1'b0;
      vvs_q <= 1'b0;
    end else if (tick) begin
      vde_q <= vid_de;
      vvs_q <= vid_vs;
      ex_q  <= vid_de ? ex_q + 8'h01 : 8'h00;
      if (vid_vs && !vvs_q) begin
        ey_q <= 8'h00;
      end else if (vde_q && !vid_de) begin
        ey_q <= ey_q + 8'h01;
      end
    end
  end

  // frame event and auto-advance through the patterns
  logic       frame_evt, auto;
  logic [3:0] scroll_q, pat;
  logic [8:0] fcnt_q;
  assign auto      = cfg_q[CFG_AUTO];
  assign frame_evt = on_q && tick && (own ? (h_last && v_last)
                                          : (vid_vs && !vvs_q));
  assign pat       = auto ? scroll_q : sel_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scroll_q <= PAT_FIRST;
      fcnt_q   <= 9'h000;
    end else if (!auto) begin
      scroll_q <= sel_q;
      fcnt_q   <= 9'h000;
    end else if (frame_evt) begin
      if (fcnt_q + 9'h001 >= 9'(tim_q[IND_DWELL])) begin
        fcnt_q   <= 9'h000;
        scroll_q <= (scroll_q >= PAT_LAST || scroll_q < PAT_FIRST)
                    ? PAT_FIRST : scroll_q + 4'h1;
      end else begin
        fcnt_q <= fcnt_q + 9'h001;
      end
    end
  end

  // colour of the current pixel
  logic [7:0] px, py, lvl, dmask;
  logic [2:0] msk, ch_bad;
  logic       custom, de_now;
  logic [7:0] exp_c [3];
  logic [7:0] rx_c [3];
  assign px     = own ? hcnt_q - h_st[7:0] : ex_q;
  assign py     = own ? vcnt_q - v_st[7:0] : ey_q;
  assign custom = pat == PAT_CUSTOM;
  assign dmask  = cfg_q[CFG_DEPTH] ? MASK_SIX : MASK_EIGHT;
  assign de_now = own ? own_de : vid_de;
  assign rx_c[0] = vid_r;
  assign rx_c[1] = vid_g;
  assign rx_c[2] = vid_b;

  always_comb begin
    lvl = 8'hFF;
    msk = 3'h0;
    case (pat)
      PAT_WHITE:  msk = 3'h7;
      PAT_RED:    msk = 3'h4;
      PAT_GREEN:  msk = 3'h2;
      PAT_BLUE:   msk = 3'h1;
      PAT_HWHITE: begin lvl = px; msk = 3'h7; end
      PAT_HGREEN: begin lvl = px; msk = 3'h2; end
      PAT_HBLUE:  begin lvl = px; msk = 3'h1; end
      PAT_HRED:   begin lvl = px; msk = 3'h4; end
      PAT_VWHITE: begin lvl = py; msk = 3'h7; end
      PAT_VRED:   begin lvl = py; msk = 3'h4; end
      PAT_VGREEN: begin lvl = py; msk = 3'h2; end
      PAT_VBLUE:  begin lvl = py; msk = 3'h1; end
      default:    msk = 3'h0;  // black and reserved codes
    endcase
  end

  // per channel: base colour, inversion, depth, compare
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic [7:0] raw;
    assign raw = custom ? tim_q[IND_CR + c] : (msk[2 - c] ? lvl : 8'h00);
    assign exp_c[c]  = (raw ^ {8{cfg_q[CFG_INV]}}) & dmask;
    assign ch_bad[c] = (rx_c[c] & dmask) != exp_c[c];
  end

  // registered video output, quiet while the generator is off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gen_de <= 1'b0;
      gen_hs <= 1'b0;
      gen_vs <= 1'b0;
      gen_r  <= 8'h00;
      gen_g  <= 8'h00;
      gen_b  <= 8'h00;
    end else if (!on_q) begin
      gen_de <= 1'b0;
      gen_hs <= 1'b0;
      gen_vs <= 1'b0;
      gen_r  <= 8'h00;
      gen_g  <= 8'h00;
      gen_b  <= 8'h00;
    end else begin
      gen_de <= de_now;
      gen_hs <= own ? own_hs : vid_hs;
      gen_vs <= own ? own_vs : vid_vs;
      gen_r  <= exp_c[0];
      gen_g  <= exp_c[1];
      gen_b  <= exp_c[2];
    end
  end

  // self-test error count, cleared when the compare is restarted
  logic bist, bist_q, mism;
  assign bist = stctl_q[STCTL_EN];
  assign mism = bist && tick && de_now && (ch_bad != 3'h0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bist_q <= 1'b0;
      err_q  <= 8'h00;
    end else begin
      bist_q <= bist;
      if (bist && !bist_q) begin
        err_q <= 8'h00;
      end else if (mism && err_q != 8'hFF) begin
        err_q <= err_q + 8'h01;
      end
    end
  end

  // sticky status, write one to clear, a new event wins
  assign st_set = {frame_evt, mism};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= IRQ_RST;
    end else if (wr_en && widx == REG_STATUS) begin
      status_q <= (status_q & ~wdat[1:0]) | st_set;
    end else begin
      status_q <= status_q | st_set;
    end
  end

  assign irq = (status_q & mask_q) != 2'h0;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_bus_two_waits: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered on third cycle");
  a_six_bit_lsbs: assert property (on_q && cfg_q[CFG_DEPTH] |=>
    gen_r[1:0] == 2'h0 && gen_g[1:0] == 2'h0 && gen_b[1:0] == 2'h0)
    else $error("six-bit mode drove low colour bits");
  a_full_white: assert property (on_q && !cfg_q[CFG_DEPTH] &&
    !cfg_q[CFG_INV] && pat == PAT_WHITE |=> gen_r == 8'hFF)
    else $error("24-bit white not full scale");
  a_invert_white: assert property (on_q && cfg_q[CFG_INV] &&
    pat == PAT_WHITE |=> gen_r == 8'h00 && gen_b == 8'h00)
    else $error("inverted white not black");
  a_div_source: assert property (own && !cfg_q[CFG_SRC] && div_tick
    |=> !div_tick ##1 div_tick)
    else $error("internal divided strobe wrong rate");
  a_source_ignored: assert property (!own |-> tick == vid_pix_stb)
    else $error("source bit acted under external timing");
  a_ext_follow: assert property (on_q && !own |=>
    gen_de == $past(vid_de) && gen_vs == $past(vid_vs))
    else $error("external timing not followed");
  a_scroll_hold: assert property (auto && !frame_evt |->
    pat == scroll_q ##1 $stable(scroll_q))
    else $error("pattern changed without a frame");
  a_fixed_hold: assert property (!auto |-> pat == sel_q)
    else $error("fixed choice not used");
  a_ind_write: assert property (ind_wr &&
    idx_q == 8'(IND_DWELL) |=> tim_q[IND_DWELL] == $past(wdat))
    else $error("indirect write lost");
  a_err_count: assert property (mism && !(bist && !bist_q) &&
    err_q != 8'hFF |=> err_q == $past(err_q) + 8'h01)
    else $error("mismatch not counted");
  a_flag_read: assert property (acc && avs_read &&
    widx == REG_RESULT |-> avs_readdata[RESULT_ERR] == ($past(err_q) != 8'h00))
    else $error("error flag disagrees with count");
  a_cfg_reset: assert property ($rose(rst_n) |-> cfg_q == CFG_RST)
    else $error("configuration not zero after reset");
endmodule : vpg_top

// ---- hw/vpg_pkg.sv ----
// constants for the video test-pattern generator with self-test compare
// assumes a 32-bit avalon slave: byte address is four times the index
// What this block does
// - depth bit one: 64 levels, six MSBs
// - depth bit zero: 24-bit, 256 levels
// - own timing: source bit picks pixel clock
// - source bit ignored under external timing
// - own timing built from programmed frame values
// - external timing follows incoming strobe, de, syncs
// - invert bit inverts every colour output
// - auto-advance after dwell frames, else hold
// - value register reaches the indexed internal byte
// - self-test compares received video to local pattern
// - error flag bit 7 while count non-zero
// - configuration register resets to all zeros
// - fixed choice ignored while auto-advance on
package vpg_pkg;
  // register indices
  localparam logic [7:0] REG_CTRL    = 8'h64;
  localparam logic [7:0] REG_CFG     = 8'h65;
  localparam logic [7:0] REG_INDEX   = 8'h66;
  localparam logic [7:0] REG_VALUE   = 8'h67;
  localparam logic [7:0] REG_STCTL   = 8'h68;
  localparam logic [7:0] REG_RESULT  = 8'h69;
  localparam logic [7:0] REG_STATUS  = 8'h70;
  localparam logic [7:0] REG_MASK    = 8'h71;
  // field positions
  localparam int CTRL_ON    = 0;
  localparam int CFG_DEPTH  = 4;
  localparam int CFG_SRC    = 3;
  localparam int CFG_OWN    = 2;
  localparam int CFG_INV    = 1;
  localparam int CFG_AUTO   = 0;
  localparam int STCTL_EN   = 3;
  localparam int RESULT_ERR = 7;
  localparam int ST_MISM    = 0;
  localparam int ST_FRAME   = 1;
  // reset values
  localparam logic [3:0] CTRL_SEL_RST = 4'h1;
  localparam logic [4:0] CFG_RST      = 5'h00;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [1:0] IRQ_RST      = 2'h0;
  // indirect indices held in flops
  localparam int IND_FLOPS = 16;
  localparam int IND_DWELL = 0;
  localparam int IND_HTOT  = 1;
  localparam int IND_VTOT  = 2;
  localparam int IND_HACT  = 3;
  localparam int IND_VACT  = 4;
  localparam int IND_HSW   = 5;
  localparam int IND_VSW   = 6;
  localparam int IND_HBP   = 7;
  localparam int IND_VBP   = 8;
  localparam int IND_SYNC  = 9;
  localparam int IND_ERR   = 10;
  localparam int IND_CR    = 11;
  // pattern codes
  localparam logic [3:0] PAT_WHITE  = 4'h1;
  localparam logic [3:0] PAT_BLACK  = 4'h2;
  localparam logic [3:0] PAT_RED    = 4'h3;
  localparam logic [3:0] PAT_GREEN  = 4'h4;
  localparam logic [3:0] PAT_BLUE   = 4'h5;
  localparam logic [3:0] PAT_HWHITE = 4'h6;
  localparam logic [3:0] PAT_HGREEN = 4'h7;
  localparam logic [3:0] PAT_HBLUE  = 4'h8;
  localparam logic [3:0] PAT_HRED   = 4'h9;
  localparam logic [3:0] PAT_VWHITE = 4'hA;
  localparam logic [3:0] PAT_VRED   = 4'hB;
  localparam logic [3:0] PAT_VGREEN = 4'hC;
  localparam logic [3:0] PAT_VBLUE  = 4'hD;
  localparam logic [3:0] PAT_CUSTOM = 4'hE;
  localparam logic [3:0] PAT_FIRST  = 4'h1;
  localparam logic [3:0] PAT_LAST   = 4'hD;
  // depth masks
  localparam logic [7:0] MASK_SIX   = 8'hFC;
  localparam logic [7:0] MASK_EIGHT = 8'hFF;
  // timing counts
  localparam logic [1:0] BUS_WAIT   = 2'h2;
  localparam logic [1:0] PIX_DIV    = 2'h2;
endpackage : vpg_pkg

// ---- hw/vpg_mem.sv ----
// byte store for indirect indices above the flop-held ones
// assumes one clock; read data registered, a same-cycle write passes on
`timescale 1ns/1ns
module vpg_mem
  import vpg_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // single port
  input  wire logic       we,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem_q [256];

  // storage write
  always_ff @(posedge clock) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  // registered read, write-first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= BYTE_RST;
    end else if (we) begin
      rdata <= wdata;
    end else begin
      rdata <= mem_q[addr];
    end
  end
endmodule : vpg_mem

// ---- dv/vpg_sender.sv ----
// upstream sender model: small external-timing frames, solid colour
// assumes the bench hands it the colour the local generator expects
`timescale 1ns/1ns
module vpg_sender (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // control from the bench
  input  wire logic       slow,
  input  wire logic       corrupt,
  input  wire logic [7:0] col_r,
  input  wire logic [7:0] col_g,
  input  wire logic [7:0] col_b,
  // video towards the receiver
  output logic            vid_pix_stb,
  output logic            vid_de,
  output logic            vid_hs,
  output logic            vid_vs,
  output logic      [7:0] vid_r,
  output logic      [7:0] vid_g,
  output logic      [7:0] vid_b
);
  logic [3:0] hc_q;
  logic [2:0] vc_q;
  logic [1:0] dv_q;
  logic       tk;
  logic       de;
  logic       bad;
  // slow mode strobes one clock in three
  assign tk  = !slow || dv_q == 2'd2;
  assign de  = hc_q >= 4'd2 && hc_q < 4'd10 && vc_q >= 3'd1 && vc_q < 3'd5;
  assign bad = corrupt && hc_q == 4'd2 && vc_q == 3'd1;
  // raster of 12 columns by 6 lines, vsync on line 0
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hc_q <= '0;
      vc_q <= '0;
      dv_q <= '0;
    end else begin
      dv_q <= (dv_q == 2'd2) ? 2'd0 : dv_q + 2'd1;
      if (tk) begin
        hc_q <= (hc_q == 4'd11) ? 4'd0 : hc_q + 4'd1;
        if (hc_q == 4'd11) begin
          vc_q <= (vc_q == 3'd5) ? 3'd0 : vc_q + 3'd1;
        end
      end
    end
  end
  // bench colour, red bit 7 flipped on the first active pixel while corrupt; blanking data keeps toggling
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vid_pix_stb <= 1'b0;
      vid_de      <= 1'b0;
      vid_hs      <= 1'b0;
      vid_vs      <= 1'b0;
      vid_r       <= '0;
      vid_g       <= '0;
      vid_b       <= '0;
    end else begin
      vid_pix_stb <= tk;
      if (tk) begin
        vid_de <= de;
        vid_hs <= hc_q == 4'd0;
        vid_vs <= vc_q == 3'd0;
        vid_r  <= de ? (col_r ^ {bad, 7'd0}) : ~vid_r;
        vid_g  <= de ? col_g : ~vid_g;
        vid_b  <= de ? col_b : ~vid_b;
      end
    end
  end
endmodule : vpg_sender

// ---- dv/vpg_top_tb.sv ----
// self-checking bench for the pattern generator and its self-test
// assumes the sender model drives the received video side
`timescale 1ns/1ns
module vpg_top_tb
  import vpg_pkg::*;
;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic vid_pix_stb, vid_de, vid_hs, vid_vs, gen_de, gen_hs, gen_vs;
  logic [7:0]  vid_r, vid_g, vid_b, gen_r, gen_g, gen_b;
  logic [7:0]  col_r, col_g, col_b, rv, wq_d, rq_d;
  logic        slow, corrupt, mon_on, ext_on, inv, six;
  logic [7:0]  cust [3];
  logic [3:0]  pat;
  logic [15:0] seed;
  logic [23:0] fpix, f0, f1;
  logic        pde, pvs, phs, dd, vd, fp;
  int num_errors, samples_checked, cyc, gx, gy, vsn, fpn, frc, frl, dec, del;
  vpg_top u_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .vid_pix_stb(vid_pix_stb), .vid_de(vid_de), .vid_hs(vid_hs),
    .vid_vs(vid_vs), .vid_r(vid_r), .vid_g(vid_g), .vid_b(vid_b),
    .gen_de(gen_de), .gen_hs(gen_hs), .gen_vs(gen_vs), .gen_r(gen_r),
    .gen_g(gen_g), .gen_b(gen_b), .irq(irq));
  vpg_sender u_snd (.clock(clock), .rst_n(rst_n), .slow(slow),
    .corrupt(corrupt), .col_r(col_r), .col_g(col_g), .col_b(col_b),
    .vid_pix_stb(vid_pix_stb), .vid_de(vid_de), .vid_hs(vid_hs),
    .vid_vs(vid_vs), .vid_r(vid_r), .vid_g(vid_g), .vid_b(vid_b));
  // clock of 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // next 16-bit state from the lfsr
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // expected colour channel for a pattern code at a position
  function automatic logic [7:0] exp_chan(input logic [3:0] p,
      input int ch, input logic [7:0] x, y);
    logic [7:0] v;
    case (p)
      PAT_WHITE:  v = 8'hFF;
      PAT_RED:    v = (ch == 0) ? 8'hFF : 8'h00;
      PAT_GREEN:  v = (ch == 1) ? 8'hFF : 8'h00;
      PAT_BLUE:   v = (ch == 2) ? 8'hFF : 8'h00;
      PAT_HWHITE: v = x;
      PAT_HGREEN: v = (ch == 1) ? x : 8'h00;
      PAT_HBLUE:  v = (ch == 2) ? x : 8'h00;
      PAT_HRED:   v = (ch == 0) ? x : 8'h00;
      PAT_VWHITE: v = y;
      PAT_VRED:   v = (ch == 0) ? y : 8'h00;
      PAT_VGREEN: v = (ch == 1) ? y : 8'h00;
      PAT_VBLUE:  v = (ch == 2) ? y : 8'h00;
      PAT_CUSTOM: v = cust[ch];
      default:    v = 8'h00;
    endcase
    if (inv) v = ~v;
    return six ? (v & MASK_SIX) : v;
  endfunction : exp_chan
  // one avalon transfer, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [7:0] idx, wd,
                      output logic [7:0] rd);
    @(posedge clock);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, wd};
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clock); while (avs_waitrequest);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, wd);
    xfer(1'b1, idx, wd, wq_d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask : rd
  task automatic wr_ind(input logic [7:0] idx, wd);
    wr(REG_INDEX, idx);
    wr(REG_VALUE, wd);
  endtask : wr_ind
  task automatic wait_vid(input int n);
    repeat (n) @(posedge vid_vs);
    @(posedge clock);
  endtask : wait_vid
  task automatic wait_gen(input int n);
    int s;
    s = vsn;
    while (vsn < s + n) @(posedge clock);
  endtask : wait_gen
  task automatic first_pix(output logic [23:0] v);
    int s;
    s = fpn;
    while (fpn == s) @(posedge clock);
    v = fpix;
  endtask : first_pix
  // generated-video monitor: timing follow, colours, frame counts
  always @(posedge clock) begin
    if (ext_on) check(gen_de, pde, "gen_de");
    if (ext_on) check(gen_vs, pvs, "gen_vs");
    if (ext_on) check(gen_hs, phs, "gen_hs");
    if (mon_on && gen_de) begin
      check(gen_r, exp_chan(pat, 0, gx[7:0], gy[7:0]), "r");
      check(gen_g, exp_chan(pat, 1, gx[7:0], gy[7:0]), "g");
      check(gen_b, exp_chan(pat, 2, gx[7:0], gy[7:0]), "b");
    end
    if (gen_de && fp) begin
      fpix = {gen_r, gen_g, gen_b};
      fpn++;
      fp = 1'b0;
    end
    if (gen_de) begin
      gx++;
      dec++;
    end else if (dd) begin
      gx = 0;
      gy++;
    end
    frc++;
    if (gen_vs && !vd) begin
      {gx, gy, fp, frl, del, frc, dec} = {32'd0, 32'd0, 1'b1, frc, dec, 64'd0};
      vsn++;
    end
    {pde, pvs, phs, dd, vd} = {vid_de, vid_vs, vid_hs, gen_de, gen_vs};
  end
  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {slow, corrupt, mon_on, ext_on, inv, six, fp, dd, vd} = '0;
    {col_r, col_g, col_b, pat} = '0;
    {num_errors, samples_checked, cyc, gx, gy, vsn, fpn, frc, dec} = '0;
    seed = 16'hEAE8;
    rst_n = 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, unmapped place and read-only result
    for (int i = 0; i < 8; i++) begin
      rd(8'h65 + i[7:0] + ((i > 4) ? 8'h06 : 8'h00), rv);
      check(rv, (i == 7) ? 8'h00 : BYTE_RST, "reset value");
    end
    wr(8'h80, 8'hFF);
    rd(8'h80, rv);
    check(rv, 8'h00, "unmapped");
    wr(REG_RESULT, 8'hFF);
    rd(REG_RESULT, rv);
    check(rv, 8'h00, "result");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(REG_CFG, seed[7:0]);
      rd(REG_CFG, rv);
      check(rv, seed[7:0] & 8'h1F, "config");
    end
    // indirect store, written then read back through the value register
    for (int i = 0; i < 15; i++) begin
      seed = lfsr(seed);
      wr_ind((i < 14) ? i[7:0] + (i > 9) : 8'h10 + seed[15:8] % 8'hE0,
             seed[7:0] ^ i[7:0]);
      f0[7:0] = seed[7:0] ^ i[7:0];
      wr(REG_INDEX, (i < 14) ? i[7:0] + (i > 9) : 8'h10 + seed[15:8] % 8'hE0);
      rd(REG_VALUE, rv);
      check(rv, f0[7:0], "indirect");
      if (i > 9 && i < 13) cust[i - 10] = f0[7:0];
    end
    // every pattern code in external timing, inversion and depth mixed
    wr_ind(8'h00, 8'h01);
    wr(8'h63, 8'h01);
    ext_on = 1'b0;
    for (int p = 1; p < 16; p++) begin
      mon_on = 1'b0;
      seed = lfsr(seed);
      {pat, inv, six, slow} = {p[3:0], p[0], p[1], p < 6 && p[0]};
      wr(REG_CTRL, {p[3:0], 4'h1});
      wr(REG_CFG, {3'b000, six, seed[0], 1'b0, inv, 1'b0});
      wait_vid(1);
      {mon_on, ext_on} = 2'b11;
      wait_vid(1);
    end
    // auto advance: every frame changes to the next pattern code, solid colours then the white ramp, then holds
    {mon_on, slow, inv, six} = '0;
    wr(REG_CTRL, {PAT_WHITE, 4'h1});
    wr(REG_CFG, 8'h01);
    wr(REG_CTRL, {PAT_BLUE, 4'h1});
    for (int i = 0; i < 3; i++) begin
      first_pix(f0);
      first_pix(f1);
      check(f0 !== f1, 1'b1, "advance");
    end
    wr(REG_CFG, 8'h00);
    wait_vid(1);
    first_pix(f0);
    first_pix(f1);
    check(f1, f0, "hold");
    // self-test against a matching sender, one bad pixel, restart
    {col_r, col_g, col_b, pat} = {8'hFF, 16'h0000, PAT_RED};
    wr(REG_CTRL, {PAT_RED, 4'h1});
    wr(REG_STCTL, 8'h08);
    wr(REG_MASK, 8'h01);
    wait_vid(2);
    rd(REG_RESULT, rv);
    check(rv, 8'h00, "flag clean");
    check(irq, 1'b0, "irq clean");
    corrupt <= 1'b1;
    wait_vid(1);
    corrupt <= 1'b0;
    wait_vid(1);
    rd(REG_RESULT, rv);
    check(rv, 8'h80, "flag set");
    wr(REG_INDEX, 8'h0A);
    rd(REG_VALUE, rv);
    check(rv, 8'h01, "error count");
    check(irq, 1'b1, "irq set");
    wr(REG_MASK, 8'h00);
    @(posedge clock);
    check(irq, 1'b0, "irq masked");
    wr(REG_MASK, 8'h01);
    wr(REG_STATUS, 8'h01);
    @(posedge clock);
    check(irq, 1'b0, "irq cleared");
    wr(REG_STCTL, 8'h00);
    wr(REG_STCTL, 8'h08);
    rd(REG_RESULT, rv);
    check(rv, 8'h00, "flag restart");
    // own timing from programmed frame values, both clock sources
    ext_on = 1'b0;
    for (int i = 1; i < 10; i++) wr_ind(i[7:0], (i == 1) ? 8'h0A :
      (i == 2) ? 8'h06 : (i == 3) ? 8'h04 : (i == 4) ? 8'h03 :
      (i == 7) ? 8'h02 : (i == 9) ? 8'h00 : 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(REG_CFG, {4'h0, s[0], 3'b100});
      wait_gen(3);
      check(frl, 60 * (s ? 1 : PIX_DIV), "frame clocks");
      check(del, 12 * (s ? 1 : PIX_DIV), "active clocks");
    end
    final_report();
  end
endmodule : vpg_top_tb
